//--- urs_pkg.sv
// shared constants and types for the receive status block
package urs_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] OFF_MODE = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_RXDATA = 12'h008;
  localparam logic [11:0] OFF_BAUD = 12'h00c;
  // serial_mode_register fields
  localparam int MODE_EN = 15;
  localparam int MODE_INV = 4;
  localparam int MODE_SEL_LSB = 1;
  localparam logic [1:0] SEL_8N = 2'h0;
  localparam logic [1:0] SEL_8E = 2'h1;
  localparam logic [1:0] SEL_8O = 2'h2;
  localparam logic [1:0] SEL_9N = 2'h3;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // uart_status_control fields
  localparam int ST_ADDRESS_DETECT_ENABLE = 5;
  localparam int ST_RECEIVER_IDLE_FLAG = 4;
  localparam int ST_PARITY_ERROR_FLAG = 3;
  localparam int ST_FRAMING_ERROR_FLAG = 2;
  localparam int ST_OVERRUN_ERROR_FLAG = 1;
  localparam int ST_RXDA = 0;
  // bit time is baud value plus one pclk cycles
  localparam logic [15:0] BAUD_RESET = 16'h0363;
  // receive fifo shape
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
  localparam int DATA_W = 9;
  localparam int ENT_W = 11;
  localparam int ENT_PARITY_ERROR_FLAG = 9;
  localparam int ENT_FRAMING_ERROR_FLAG = 10;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  typedef enum logic [2:0] {URS_IDLE, URS_START, URS_DATA, URS_PARITY, URS_STOP} urs_state_t;
endpackage : urs_pkg

//--- urs_sync.sv
// two-flop synchroniser for inputs from outside the pclk domain
module urs_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  // resets to ones, the mark level of the line; first stage only feeds the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '1;
      sync_out <= '1;
    end
    else if (pce)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : urs_sync

//--- urs_top.sv
// receive side of an async serial port with apb status and control registers
// Behaviour
// - receive input idles high when polarity invert is 0, low when 1
// - during sleep the bit sampling baud counter is stopped
// - first character after wake from sleep may be corrupt; software expects it
// - address detect enable works only in 9-bit mode, keyed on ninth bit
// - receiver idle flag reads 1 when idle, 0 while receiving
// - parity error flag describes the character at the fifo head
// - framing error flag describes the character at the fifo head
// - overflow sets overrun flag; software clearing it empties fifo and shifter
// - data available flag is 1 while the fifo holds an unread character
//
// Implementation choices: register access over APB and the placing of the registers.
module urs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic serial_receive_pin,
  input wire logic sleep_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] mode_reg;
  logic [15:0] baud_reg;
  logic address_detect_enable_reg;
  logic overrun_error_flag_reg;
  urs_pkg::urs_state_t state_reg;
  urs_pkg::urs_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [15:0] baud_cnt_reg;
  logic [15:0] baud_cnt_next;
  logic [urs_pkg::DATA_W-1:0] rx_shift_register;
  logic [urs_pkg::DATA_W-1:0] shift_next;
  logic par_reg;
  logic par_next;
  logic char_done;
  logic [urs_pkg::ENT_W-1:0] fifo_mem [urs_pkg::FIFO_DEPTH];
  logic [urs_pkg::PTR_W-1:0] wr_ptr_reg;
  logic [urs_pkg::PTR_W-1:0] rd_ptr_reg;
  logic [urs_pkg::CNT_W-1:0] count_reg;
  logic [urs_pkg::CNT_W-1:0] count_next;
  logic [1:0] sync_q;
  logic [15:0] stat_word;
  logic [31:0] rd_mux;

  // pin and sleep request cross into pclk; line idles as a mark level
  urs_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .async_in({serial_receive_pin, sleep_req}),
    .sync_out(sync_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so every answer comes from a flop
  wire rx_sync = sync_q[1];
  wire sleeping = sync_q[0];
  wire acc = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire hit_mode = (paddr == urs_pkg::OFF_MODE);
  wire hit_stat = (paddr == urs_pkg::OFF_STAT);
  wire hit_rx = (paddr == urs_pkg::OFF_RXDATA);
  wire hit_baud = (paddr == urs_pkg::OFF_BAUD);
  wire hit_any = hit_mode | hit_stat | hit_rx | hit_baud;
  wire wr_done = done & pwrite & ~pslverr;
  wire rx_en = mode_reg[urs_pkg::MODE_EN];
  wire [1:0] sel = mode_reg[urs_pkg::MODE_SEL_LSB +: 2];
  wire mode9 = (sel == urs_pkg::SEL_9N);
  wire par_en = (sel == urs_pkg::SEL_8E) | (sel == urs_pkg::SEL_8O);
  wire [3:0] last_bit = mode9 ? urs_pkg::LAST_BIT9 : urs_pkg::LAST_BIT8;
  wire rx_bit = rx_sync ^ mode_reg[urs_pkg::MODE_INV];
  wire baud_tick = (baud_cnt_reg == 16'h0000) & ~sleeping;
  wire addr_mode = address_detect_enable_reg & mode9;
  wire accept = ~addr_mode | rx_shift_register[urs_pkg::DATA_W-1];
  wire fifo_full = (count_reg == urs_pkg::CNT_FULL);
  wire fifo_empty = (count_reg == '0);
  wire push = char_done & accept & ~fifo_full & ~overrun_error_flag_reg;
  wire overrun_evt = char_done & accept & fifo_full;
  wire pop = done & ~pwrite & hit_rx & ~fifo_empty;
  // clear only acts on a 1 to 0 change of the flag
  wire overrun_error_flag_clear = wr_done & hit_stat & overrun_error_flag_reg & ~pwdata[urs_pkg::ST_OVERRUN_ERROR_FLAG];
  wire [urs_pkg::ENT_W-1:0] head = fifo_mem[rd_ptr_reg];
  wire framing_error_flag_c = ~rx_bit;
  // even parity: data plus parity xor to 0; odd: to 1
  wire parity_error_flag_c = par_en & ((^{rx_shift_register[7:0], par_reg}) != (sel == urs_pkg::SEL_8O));

  ////////////////////////////////////////////////////////////////////////////
  // receive bit sequencer; sleep freezes the baud counter but not start detection,
  // so a start edge during sleep is sampled late and that character may be bad
  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    baud_cnt_next = baud_cnt_reg;
    shift_next = rx_shift_register;
    par_next = par_reg;
    char_done = 1'b0;
    if (state_reg != urs_pkg::URS_IDLE && !sleeping)
      baud_cnt_next = baud_tick ? baud_reg : baud_cnt_reg - 16'h0001;
    case (state_reg)
      urs_pkg::URS_IDLE:
        if (!rx_bit)
        begin
          state_next = urs_pkg::URS_START;
          baud_cnt_next = {1'b0, baud_reg[15:1]};
          shift_next = '0;
        end
      urs_pkg::URS_START:
        if (baud_tick)
        begin
          state_next = rx_bit ? urs_pkg::URS_IDLE : urs_pkg::URS_DATA;
          bit_cnt_next = 4'h0;
        end
      urs_pkg::URS_DATA:
        if (baud_tick)
        begin
          shift_next[bit_cnt_reg] = rx_bit;
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == last_bit)
            state_next = par_en ? urs_pkg::URS_PARITY : urs_pkg::URS_STOP;
        end
      urs_pkg::URS_PARITY:
        if (baud_tick)
        begin
          par_next = rx_bit;
          state_next = urs_pkg::URS_STOP;
        end
      urs_pkg::URS_STOP:
        if (baud_tick)
        begin
          char_done = 1'b1;
          state_next = urs_pkg::URS_IDLE;
        end
      default:
        state_next = urs_pkg::URS_IDLE;
    endcase
    // overrun clear resets the shifter to empty as well as the fifo
    if (!rx_en || overrun_error_flag_clear)
    begin
      state_next = urs_pkg::URS_IDLE;
      shift_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= urs_pkg::URS_IDLE;
      bit_cnt_reg <= 4'h0;
      baud_cnt_reg <= 16'h0000;
      rx_shift_register <= '0;
      par_reg <= 1'b0;
    end
    else if (pce)
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      baud_cnt_reg <= baud_cnt_next;
      rx_shift_register <= shift_next;
      par_reg <= par_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive fifo; errors ride with each character so flags track the head
  assign count_next = overrun_error_flag_clear ? '0 : count_reg + {2'h0, push} - {2'h0, pop};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (pce)
    begin
      wr_ptr_reg <= overrun_error_flag_clear ? '0 : wr_ptr_reg + PTR_INC(push);
      rd_ptr_reg <= overrun_error_flag_clear ? '0 : rd_ptr_reg + PTR_INC(pop);
      count_reg <= count_next;
    end
  end

  function automatic logic [urs_pkg::PTR_W-1:0] PTR_INC(input logic b);
    PTR_INC = {{(urs_pkg::PTR_W-1){1'b0}}, b};
  endfunction : PTR_INC

  // storage needs no reset: count gates every read of it
  always_ff @(posedge pclk)
  begin
    if (pce && push)
      fifo_mem[wr_ptr_reg] <= {framing_error_flag_c, parity_error_flag_c, rx_shift_register};
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; a new overrun wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= urs_pkg::MODE_RESET;
      baud_reg <= urs_pkg::BAUD_RESET;
      address_detect_enable_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
    end
    else if (pce)
    begin
      if (wr_done && hit_mode)
        mode_reg <= pwdata[15:0];
      if (wr_done && hit_baud)
        baud_reg <= pwdata[15:0];
      if (wr_done && hit_stat)
        address_detect_enable_reg <= pwdata[urs_pkg::ST_ADDRESS_DETECT_ENABLE];
      overrun_error_flag_reg <= overrun_evt | (overrun_error_flag_reg & ~overrun_error_flag_clear);
    end
  end

  // status view: head flags read 0 when the fifo is empty
  always_comb
  begin
    stat_word = 16'h0000;
    stat_word[urs_pkg::ST_ADDRESS_DETECT_ENABLE] = address_detect_enable_reg;
    stat_word[urs_pkg::ST_RECEIVER_IDLE_FLAG] = (state_reg == urs_pkg::URS_IDLE);
    stat_word[urs_pkg::ST_PARITY_ERROR_FLAG] = ~fifo_empty & head[urs_pkg::ENT_PARITY_ERROR_FLAG];
    stat_word[urs_pkg::ST_FRAMING_ERROR_FLAG] = ~fifo_empty & head[urs_pkg::ENT_FRAMING_ERROR_FLAG];
    stat_word[urs_pkg::ST_OVERRUN_ERROR_FLAG] = overrun_error_flag_reg;
    stat_word[urs_pkg::ST_RXDA] = ~fifo_empty;
  end

  assign rd_mux = hit_mode ? {16'h0000, mode_reg} :
                  hit_stat ? {16'h0000, stat_word} :
                  hit_baud ? {16'h0000, baud_reg} :
                  (hit_rx && !fifo_empty) ? {23'h000000, head[urs_pkg::DATA_W-1:0]} : 32'h00000000;

  // answer flops: data and error latch in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (pce)
    begin
      pready <= acc;
      if (acc)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= ~hit_any;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_level;
    (state_reg == urs_pkg::URS_IDLE) && pce && rx_en && !overrun_error_flag_clear
      |=> (state_reg == urs_pkg::URS_START) ==
          ($past(rx_sync) == $past(mode_reg[urs_pkg::MODE_INV]));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("start detect ignores polarity");

  property p_sleep_freeze;
    sleeping && pce && rx_en && !overrun_error_flag_clear && (state_reg != urs_pkg::URS_IDLE)
      |=> $stable(baud_cnt_reg) && (state_reg == $past(state_reg));
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("sampling ran in sleep");

  property p_receiver_idle_flag_read;
    acc && !pwrite && hit_stat && pce
      |=> prdata[urs_pkg::ST_RECEIVER_IDLE_FLAG] == ($past(state_reg) == urs_pkg::URS_IDLE);
  endproperty
  a_receiver_idle_flag_read: assert property (p_receiver_idle_flag_read) else $error("idle flag wrong");

  property p_head_errs;
    acc && !pwrite && hit_stat && pce
      |=> prdata[urs_pkg::ST_FRAMING_ERROR_FLAG +: 2] == ($past(fifo_empty) ? 2'h0 :
          $past({head[urs_pkg::ENT_PARITY_ERROR_FLAG], head[urs_pkg::ENT_FRAMING_ERROR_FLAG]}));
  endproperty
  a_head_errs: assert property (p_head_errs) else $error("error flags not from head");

  property p_overrun_error_flag_flush;
    overrun_error_flag_clear && !overrun_evt && pce
      |=> !overrun_error_flag_reg && fifo_empty && (rx_shift_register == '0) && (state_reg == urs_pkg::URS_IDLE);
  endproperty
  a_overrun_error_flag_flush: assert property (p_overrun_error_flag_flush) else $error("overrun clear did not flush");

  property p_overrun_error_flag_set;
    // a clear in the same cycle still flushes, only the flag survives
    overrun_evt && pce |=> overrun_error_flag_reg && (count_reg == ($past(overrun_error_flag_clear) ? 3'h0 :
      urs_pkg::CNT_FULL - {2'h0, $past(pop)}));
  endproperty
  a_overrun_error_flag_set: assert property (p_overrun_error_flag_set) else $error("overrun lost");

  property p_rxda_drop;
    pop && (count_reg == 3'h1) && !push && !overrun_error_flag_clear && pce ##1 !push [*2]
      |-> !stat_word[urs_pkg::ST_RXDA];
  endproperty
  a_rxda_drop: assert property (p_rxda_drop) else $error("data flag stays set");

  property p_addr_filter;
    char_done && addr_mode && !rx_shift_register[urs_pkg::DATA_W-1] |-> !push && !overrun_evt;
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("data char kept in address mode");

  property p_advance;
    pop && !overrun_error_flag_clear && pce |=> rd_ptr_reg == $past(rd_ptr_reg) + PTR_INC(1'b1);
  endproperty
  a_advance: assert property (p_advance) else $error("head did not advance");

  property p_one_wait;
    acc && pce |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("apb answer timing");
endmodule : urs_top

//--- urs_node.sv
// model of the remote serial node that drives the receive line
module urs_node #(
  parameter int BIT = 8
) (
  input wire logic clk,
  input wire logic inv,
  output logic line
);
  logic lvl = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // released line rests at its pull level: pull-up for inv 0, pull-down for 1
  assign line = lvl ^ inv;
  ////////////////////////////////////////////////////////////////////////////
  // one bit held for a full bit time
  task automatic put(input logic b);
    lvl <= b;
    repeat (BIT) @(posedge clk);
  endtask : put
  // start, data lsb first, optional parity, stop; bad stop ends early
  // so the receiver sees a clean high before it could take a false start
  task automatic send(input logic [8:0] d, input int nb, input logic hp, input logic pb,
                      input logic bs);
    put(1'b0);
    for (int i = 0; i < nb; i++)
    begin
      put(d[i]);
    end
    if (hp) put(pb);
    if (bs)
    begin
      lvl <= 1'b0;
      repeat (BIT - 3) @(posedge clk);
      put(1'b1);
    end
    else put(1'b1);
  endtask : send
endmodule : urs_node

//--- urs_top_tb.sv
// self-checking bench for the receive status block
module urs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 8;
  localparam logic [31:0] IB = 32'h1 << urs_pkg::ST_RECEIVER_IDLE_FLAG;
  localparam logic [31:0] DA = 32'h1 << urs_pkg::ST_RXDA;
  localparam logic [31:0] PE = 32'h1 << urs_pkg::ST_PARITY_ERROR_FLAG;
  localparam logic [31:0] FE = 32'h1 << urs_pkg::ST_FRAMING_ERROR_FLAG;
  localparam logic [31:0] OE = 32'h1 << urs_pkg::ST_OVERRUN_ERROR_FLAG;
  localparam logic [31:0] AD = 32'h1 << urs_pkg::ST_ADDRESS_DETECT_ENABLE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_req = 1'b0, inv = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, err;
  logic [31:0] prdata, rdv;
  wire logic rx_line;
  int n_errors = 0, n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // design and far-side node
  urs_top uut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .serial_receive_pin(rx_line),
    .sleep_req(sleep_req), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  urs_node #(.BIT(BIT)) node (.clk(pclk), .inv(inv), .line(rx_line));
  // free-running clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // mode word: enable, format select, polarity
  function automatic logic [31:0] md(input logic [1:0] s, input logic iv, input logic en);
    return (32'(en) << urs_pkg::MODE_EN) | (32'(s) << urs_pkg::MODE_SEL_LSB) |
      (32'(iv) << urs_pkg::MODE_INV);
  endfunction : md
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  // apb transfer; waits on pready, bounded, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask : rd
  // one character, then settle time for sync and push
  task automatic tx(input logic [8:0] d, input int nb, input logic hp, input logic pb,
                    input logic bs);
    node.send(d, nb, hp, pb, bs);
    repeat (6) @(posedge pclk);
  endtask : tx
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the ~1700 cycles the tests need
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("mode", urs_pkg::OFF_MODE, 32'(urs_pkg::MODE_RESET));
    rd("baud", urs_pkg::OFF_BAUD, 32'(urs_pkg::BAUD_RESET));
    rd("status", urs_pkg::OFF_STAT, IB);
    rd("unmapped", 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    wr(urs_pkg::OFF_BAUD, 32'(BIT - 1));
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8N, 1'b0, 1'b1));
    $display("test reset done");
    fork
      tx(9'h05a, 8, 1'b0, 1'b0, 1'b0);
      begin
        repeat (3 * BIT) @(posedge pclk);
        apb(1'b0, urs_pkg::OFF_STAT, 32'h0);
        chk("idle busy", 32'h0, rdv & IB);
      end
    join
    rd("status", urs_pkg::OFF_STAT, IB | DA);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h05a);
    rd("status", urs_pkg::OFF_STAT, IB);
    $display("test receive done");
    // good, bad parity, bad stop: flags follow the fifo head
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8E, 1'b0, 1'b1));
    tx(9'h0c3, 8, 1'b1, ^8'hc3, 1'b0);
    tx(9'h081, 8, 1'b1, ~^8'h81, 1'b0);
    tx(9'h07e, 8, 1'b1, ^8'h7e, 1'b1);
    rd("status", urs_pkg::OFF_STAT, IB | DA);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h0c3);
    rd("status", urs_pkg::OFF_STAT, IB | DA | PE);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h081);
    rd("status", urs_pkg::OFF_STAT, IB | DA | FE);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h07e);
    rd("status", urs_pkg::OFF_STAT, IB);
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8O, 1'b0, 1'b1));
    tx(9'h0c3, 8, 1'b1, ~^8'hc3, 1'b0);
    rd("status", urs_pkg::OFF_STAT, IB | DA);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h0c3);
    $display("test errors done");
    // one character more than the fifo holds
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8N, 1'b0, 1'b1));
    for (int i = 0; i <= urs_pkg::FIFO_DEPTH; i++) tx(9'(i + 1), 8, 1'b0, 1'b0, 1'b0);
    rd("status", urs_pkg::OFF_STAT, IB | DA | OE);
    wr(urs_pkg::OFF_STAT, OE);
    rd("status", urs_pkg::OFF_STAT, IB | DA | OE);
    wr(urs_pkg::OFF_STAT, 32'h0);
    rd("status", urs_pkg::OFF_STAT, IB);
    $display("test overrun done");
    // address detect: data character dropped in 9-bit mode only
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_9N, 1'b0, 1'b1));
    wr(urs_pkg::OFF_STAT, AD);
    tx(9'h0aa, 9, 1'b0, 1'b0, 1'b0);
    tx(9'h1a5, 9, 1'b0, 1'b0, 1'b0);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h1a5);
    rd("status", urs_pkg::OFF_STAT, IB | AD);
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8N, 1'b0, 1'b1));
    tx(9'h033, 8, 1'b0, 1'b0, 1'b0);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h033);
    wr(urs_pkg::OFF_STAT, 32'h0);
    $display("test address done");
    // flip polarity with the receiver off to avoid a false start
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8N, 1'b1, 1'b0));
    inv <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(urs_pkg::OFF_MODE, md(urs_pkg::SEL_8N, 1'b1, 1'b1));
    tx(9'h03c, 8, 1'b0, 1'b0, 1'b0);
    rd("rxdata", urs_pkg::OFF_RXDATA, 32'h03c);
    $display("test polarity done");
    // asleep the bit timing stands; the character itself is not trusted
    sleep_req <= 1'b1;
    tx(9'h055, 8, 1'b0, 1'b0, 1'b0);
    apb(1'b0, urs_pkg::OFF_STAT, 32'h0);
    chk("idle asleep", 32'h0, rdv & IB);
    sleep_req <= 1'b0;
    repeat (20 * BIT) @(posedge pclk);
    apb(1'b0, urs_pkg::OFF_STAT, 32'h0);
    chk("idle woken", IB, rdv & IB);
    $display("test sleep done");
    stop_test();
  end
endmodule : urs_top_tb
